/* File: verilog/rff_consts.vh */
/*
  Constants for the radio framing FIFO and line encoder.
  Assumes inclusion by bare name from design files.
*/
`ifndef RFF_CONSTS_VH
`define RFF_CONSTS_VH

// FIFO geometry
`define RFF_FIFO_DEPTH    256
`define RFF_PTR_W         8
`define RFF_CNT_W         9
`define RFF_CNT_FULL      9'h100
`define RFF_CNT_ZERO      9'h000

// Line coding field positions in line_coding_config
`define RFF_LC_INV        0
`define RFF_LC_DIFF       1
`define RFF_LC_MANCH      2
`define RFF_LC_WHITE      3
`define RFF_LC_W          4

// Framing mode
`define RFF_MODE_PACKET   1'b0
`define RFF_MODE_RAW      1'b1

// Whitening scrambler, x^9 + x^5 + 1 self synchronizing
`define RFF_WH_W          9
`define RFF_WH_TAP_A      8
`define RFF_WH_TAP_B      4

// Serializer
`define RFF_BIT_CNT_W     3
`define RFF_BIT_LAST      3'h7
`define RFF_BIT_ZERO      3'h0

// Chunk header: length in low bits, type in upper bits
`define RFF_CHK_LEN_LSB   0
`define RFF_CHK_LEN_MSB   4
`define RFF_CHK_TYPE_LSB  5
`define RFF_CHK_TYPE_MSB  7

// Filter bandwidth limits in Hz
`define RFF_BW_MIN_HZ     995
`define RFF_BW_MAX_HZ     221000

// Channel filter decimation range
`define RFF_DECIM_W       7
`define RFF_DECIM_MIN     7'h01
`define RFF_DECIM_MAX     7'h7f

// Modulation select width
`define RFF_MOD_W         4

`endif

/* File: verilog/rff_skid_buf.v */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a single clock and active low asynchronous reset.
*/
`timescale 1ns/1ps
`include "rff_consts.vh"

module rff_skid_buf (
  // Clock and reset
  input  wire       mclk_in,
  input  wire       arst_n_in,
  // Upstream
  input  wire [7:0] up_data_in,
  input  wire       up_valid_in,
  output wire       up_ready_out,
  // Downstream
  output wire [7:0] dn_data_out,
  output wire       dn_valid_out,
  input  wire       dn_ready_in
);

  reg [7:0] ent0_q;
  reg [7:0] ent1_q;
  reg [1:0] cnt_q;

  wire push = up_valid_in & up_ready_out;
  wire pop  = dn_valid_out & dn_ready_in;

  assign up_ready_out = (cnt_q != 2'h2);
  assign dn_valid_out = (cnt_q != 2'h0);
  assign dn_data_out  = ent0_q;

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ent0_q <= 8'h00;
      ent1_q <= 8'h00;
      cnt_q  <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) ent0_q <= up_data_in;
          else               ent1_q <= up_data_in;
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          ent0_q <= ent1_q;
          cnt_q  <= cnt_q - 2'h1;
        end
        2'b11: begin
          if (cnt_q == 2'h1) ent0_q <= up_data_in;
          else begin
            ent0_q <= ent1_q;
            ent1_q <= up_data_in;
          end
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

endmodule

/* File: verilog/rff_framer.v */
/*
  Radio framing unit: 256-byte direction-switched FIFO, byte serializer and
  deserializer, and line encoder/decoder between framing and the modem.
  Assumes one clock, symbol strobes from the modem, configuration held steady
  while a transfer runs.
*/
`timescale 1ns/1ps
`include "rff_consts.vh"

module rff_framer (
  // Clock and reset
  input  wire                    mclk_in,
  input  wire                    arst_n_in,
  // Configuration
  input  wire                    tx_mode_in,
  input  wire                    frame_mode_in,
  input  wire [`RFF_LC_W-1:0]    line_coding_config_in,
  input  wire [`RFF_CNT_W-1:0]   fifo_thresh_in,
  input  wire [`RFF_DECIM_W-1:0] channel_filter_decim_in,
  input  wire [`RFF_MOD_W-1:0]   mod_scheme_select_in,
  input  wire [7:0]              tx_freq_deviation_in,
  input  wire [7:0]              timing_loop_gain_in,
  input  wire [7:0]              rate_loop_gain_in,
  // Microcontroller FIFO port
  input  wire                    host_wr_in,
  input  wire [7:0]              host_wdata_in,
  input  wire                    host_rd_in,
  output reg  [7:0]              host_rdata_out,
  output reg                     host_rvalid_out,
  // FIFO status
  output wire [`RFF_CNT_W-1:0]   fifo_count_out,
  output wire                    irq_empty_out,
  output wire                    irq_not_empty_out,
  output wire                    irq_full_out,
  output wire                    irq_not_full_out,
  output wire                    irq_level_out,
  output wire                    chunk_start_out,
  // Modulator side
  input  wire                    mod_sym_strobe_in,
  output reg                     mod_bit_out,
  output reg                     mod_active_out,
  // Demodulator side
  input  wire                    demod_sym_strobe_in,
  input  wire                    demod_bit_in,
  // Modem configuration outputs
  output reg  [`RFF_DECIM_W-1:0] filt_decim_out,
  output reg  [`RFF_MOD_W-1:0]   tx_mod_out,
  output reg  [`RFF_MOD_W-1:0]   rx_mod_out,
  output reg  [7:0]              tx_dev_out,
  output reg  [7:0]              rx_tgain_out,
  output reg  [7:0]              rx_rgain_out
);

  function [`RFF_WH_W-1:0] wh_shift;
    input [`RFF_WH_W-1:0] st;
    input                 b;
    begin
      wh_shift = {st[`RFF_WH_W-2:0], b};
    end
  endfunction

  function wh_fb;
    input [`RFF_WH_W-1:0] st;
    begin
      wh_fb = st[`RFF_WH_TAP_A] ^ st[`RFF_WH_TAP_B];
    end
  endfunction

  // ==========================================================
  // Modem configuration
  // ==========================================================
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      filt_decim_out <= `RFF_DECIM_MIN;
      tx_mod_out     <= {`RFF_MOD_W{1'b0}};
      rx_mod_out     <= {`RFF_MOD_W{1'b0}};
      tx_dev_out     <= 8'h00;
      rx_tgain_out   <= 8'h00;
      rx_rgain_out   <= 8'h00;
    end else begin
      if (channel_filter_decim_in < `RFF_DECIM_MIN)
        filt_decim_out <= `RFF_DECIM_MIN;
      else
        filt_decim_out <= channel_filter_decim_in;
      tx_mod_out   <= mod_scheme_select_in;
      rx_mod_out   <= mod_scheme_select_in;
      tx_dev_out   <= tx_freq_deviation_in;
      rx_tgain_out <= timing_loop_gain_in;
      rx_rgain_out <= rate_loop_gain_in;
    end
  end

  // ==========================================================
  // FIFO
  // ==========================================================
  reg [7:0]            mem [0:`RFF_FIFO_DEPTH-1];
  reg [`RFF_PTR_W-1:0] wptr_q;
  reg [`RFF_PTR_W-1:0] rptr_q;
  reg [`RFF_CNT_W-1:0] cnt_q;
  reg [`RFF_CHK_LEN_MSB:0] chunk_left_q;

  wire fifo_full  = (cnt_q == `RFF_CNT_FULL);
  wire fifo_empty = (cnt_q == `RFF_CNT_ZERO);

  wire       rx_byte_valid;
  wire [7:0] rx_byte;
  wire       rx_buf_ready;
  wire       tx_pull;

  // Writer and reader chosen by direction
  wire wr_src  = tx_mode_in ? host_wr_in : (rx_byte_valid & ~tx_mode_in);
  wire [7:0] wr_data = tx_mode_in ? host_wdata_in : rx_byte;
  wire rd_src  = tx_mode_in ? tx_pull : host_rd_in;
  wire do_wr   = wr_src & ~fifo_full;
  wire do_rd   = rd_src & ~fifo_empty;

  assign rx_buf_ready = ~fifo_full;
  assign fifo_count_out    = cnt_q;
  assign irq_empty_out     = fifo_empty;
  assign irq_not_empty_out = ~fifo_empty;
  assign irq_full_out      = fifo_full;
  assign irq_not_full_out  = ~fifo_full;
  assign irq_level_out     = (cnt_q >= fifo_thresh_in);
  assign chunk_start_out   = (chunk_left_q == {(`RFF_CHK_LEN_MSB+1){1'b0}});

  always @(posedge mclk_in) begin
    if (do_wr)
      mem[wptr_q] <= wr_data;
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr_q          <= {`RFF_PTR_W{1'b0}};
      rptr_q          <= {`RFF_PTR_W{1'b0}};
      cnt_q           <= `RFF_CNT_ZERO;
      host_rdata_out  <= 8'h00;
      host_rvalid_out <= 1'b0;
      chunk_left_q    <= {(`RFF_CHK_LEN_MSB+1){1'b0}};
    end else begin
      if (do_wr)
        wptr_q <= wptr_q + 8'h01;
      if (do_rd)
        rptr_q <= rptr_q + 8'h01;
      case ({do_wr, do_rd})
        2'b10:   cnt_q <= cnt_q + 9'h001;
        2'b01:   cnt_q <= cnt_q - 9'h001;
        default: cnt_q <= cnt_q;
      endcase
      host_rvalid_out <= do_rd & ~tx_mode_in;
      if (do_rd & ~tx_mode_in)
        host_rdata_out <= mem[rptr_q];
      // Chunk tracking on the host write stream
      if (do_wr & tx_mode_in) begin
        if (chunk_start_out)
          chunk_left_q <= wr_data[`RFF_CHK_LEN_MSB:`RFF_CHK_LEN_LSB];
        else
          chunk_left_q <= chunk_left_q - 5'h01;
      end
    end
  end

  // ==========================================================
  // Transmit serializer and encoder
  // ==========================================================
  wire       txb_valid;
  wire [7:0] txb_data;
  reg        txb_take;
  wire       txb_ready;

  assign tx_pull = tx_mode_in & txb_ready & ~fifo_empty;

  rff_skid_buf u_tx_buf (
    .mclk_in      (mclk_in),
    .arst_n_in    (arst_n_in),
    .up_data_in   (mem[rptr_q]),
    .up_valid_in  (tx_pull),
    .up_ready_out (txb_ready),
    .dn_data_out  (txb_data),
    .dn_valid_out (txb_valid),
    .dn_ready_in  (txb_take)
  );

  reg [7:0]                sh_q;
  reg [`RFF_BIT_CNT_W-1:0] bit_q;
  reg                      busy_q;
  reg                      half_q;
  reg                      lvl_q;
  reg [`RFF_WH_W-1:0]      txwh_q;
  reg                      sym_q;

  wire [`RFF_LC_W-1:0] lc = line_coding_config_in;
  wire raw_bit  = sh_q[0];
  wire wh_bit   = lc[`RFF_LC_WHITE] ? (raw_bit ^ wh_fb(txwh_q)) : raw_bit;
  wire dif_bit  = lc[`RFF_LC_DIFF] ? (lvl_q ^ wh_bit) : wh_bit;
  wire inv_bit  = lc[`RFF_LC_INV] ? ~dif_bit : dif_bit;
  wire manch    = lc[`RFF_LC_MANCH];
  wire last_sym = ~manch | half_q;

  always @* begin
    txb_take = tx_mode_in & txb_valid &
               (~busy_q | (mod_sym_strobe_in & last_sym & (bit_q == `RFF_BIT_LAST)));
  end

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sh_q           <= 8'h00;
      bit_q          <= `RFF_BIT_ZERO;
      busy_q         <= 1'b0;
      half_q         <= 1'b0;
      lvl_q          <= 1'b0;
      txwh_q         <= {`RFF_WH_W{1'b0}};
      sym_q          <= 1'b0;
      mod_bit_out    <= 1'b0;
      mod_active_out <= 1'b0;
    end else begin
      mod_active_out <= busy_q & tx_mode_in;
      if (busy_q & mod_sym_strobe_in) begin
        sym_q <= inv_bit;
        mod_bit_out <= (manch & half_q) ? ~sym_q : inv_bit;
        if (manch & ~half_q)
          half_q <= 1'b1;
        else begin
          half_q <= 1'b0;
          lvl_q  <= dif_bit;
          txwh_q <= wh_shift(txwh_q, wh_bit);
          sh_q   <= {1'b0, sh_q[7:1]};
          bit_q  <= bit_q + 3'h1;
          if (bit_q == `RFF_BIT_LAST)
            busy_q <= 1'b0;
        end
      end
      if (txb_take) begin
        sh_q   <= txb_data;
        bit_q  <= `RFF_BIT_ZERO;
        busy_q <= 1'b1;
        half_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receive decoder and deserializer
  // ==========================================================
  reg [7:0]                rsh_q;
  reg [`RFF_BIT_CNT_W-1:0] rbit_q;
  reg                      rhalf_q;
  reg                      rprev_q;
  reg [`RFF_WH_W-1:0]      rxwh_q;
  reg                      rx_word_v_q;
  reg [7:0]                rx_word_q;

  // Manchester decodes on the second half, whose symbol is the complement
  wire rx_inv  = lc[`RFF_LC_INV] ? ~demod_bit_in : demod_bit_in;
  wire rx_sym  = manch ? ~rx_inv : rx_inv;
  wire rx_dif  = lc[`RFF_LC_DIFF] ? (rx_sym ^ rprev_q) : rx_sym;
  wire rx_dat  = lc[`RFF_LC_WHITE] ? (rx_dif ^ wh_fb(rxwh_q)) : rx_dif;
  wire rx_bit_ev = demod_sym_strobe_in & ~tx_mode_in & (~manch | rhalf_q);
  wire rx_ok     = rx_word_v_q;
  wire rx_buf_ready_s;
  wire rx_acc    = rx_ok & rx_buf_ready_s;

  rff_skid_buf u_rx_buf (
    .mclk_in      (mclk_in),
    .arst_n_in    (arst_n_in),
    .up_data_in   (rx_word_q),
    .up_valid_in  (rx_ok),
    .up_ready_out (rx_buf_ready_s),
    .dn_data_out  (rx_byte),
    .dn_valid_out (rx_byte_valid),
    .dn_ready_in  (rx_buf_ready)
  );

  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsh_q       <= 8'h00;
      rbit_q      <= `RFF_BIT_ZERO;
      rhalf_q     <= 1'b0;
      rprev_q     <= 1'b0;
      rxwh_q      <= {`RFF_WH_W{1'b0}};
      rx_word_v_q <= 1'b0;
      rx_word_q   <= 8'h00;
    end else begin
      if (rx_acc)
        rx_word_v_q <= 1'b0;
      if (demod_sym_strobe_in & ~tx_mode_in & manch)
        rhalf_q <= ~rhalf_q;
      if (rx_bit_ev) begin
        rprev_q <= rx_sym;
        rxwh_q <= wh_shift(rxwh_q, rx_dif);
        rsh_q  <= {rx_dat, rsh_q[7:1]};
        rbit_q <= rbit_q + 3'h1;
        // Raw mode groups every eight bits; packet mode waits for a nonzero byte
        if (rbit_q == `RFF_BIT_LAST &&
            (frame_mode_in == `RFF_MODE_RAW || {rx_dat, rsh_q[7:1]} != 8'h00)) begin
          rx_word_q   <= {rx_dat, rsh_q[7:1]};
          rx_word_v_q <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: test/rff_framer_asserts.sv */
/*
  Checker for rff_framer FIFO flags, host reads and modem config outputs.
  Assumes binding to the ports of rff_framer in one clock domain.
*/
`timescale 1ns/1ps
`include "rff_consts.vh"

module rff_framer_chk (
  // Clock and reset
  input wire                    mclk_in,
  input wire                    arst_n_in,
  // Configuration
  input wire                    tx_mode_in,
  input wire [`RFF_CNT_W-1:0]   fifo_thresh_in,
  input wire [`RFF_MOD_W-1:0]   mod_scheme_select_in,
  // Host port
  input wire                    host_rd_in,
  input wire                    host_rvalid_out,
  // Status
  input wire [`RFF_CNT_W-1:0]   fifo_count_out,
  input wire                    irq_empty_out,
  input wire                    irq_not_empty_out,
  input wire                    irq_full_out,
  input wire                    irq_not_full_out,
  input wire                    irq_level_out,
  // Modem config
  input wire [`RFF_DECIM_W-1:0] filt_decim_out,
  input wire [`RFF_MOD_W-1:0]   tx_mod_out,
  input wire [`RFF_MOD_W-1:0]   rx_mod_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================================
  // Read sequences
  sequence s_rd_ok;
    host_rd_in && !tx_mode_in && fifo_count_out != 9'h000;
  endsequence
  sequence s_rd_empty;
    host_rd_in && fifo_count_out == 9'h000;
  endsequence

  // ==========================================================
  // Properties
  property p_empty;    irq_empty_out == (fifo_count_out == 9'h000); endproperty
  property p_nempty;   irq_not_empty_out == (fifo_count_out != 9'h000); endproperty
  property p_full;     irq_full_out == (fifo_count_out == 9'h100); endproperty
  property p_nfull;    irq_not_full_out == (fifo_count_out != 9'h100); endproperty
  property p_level;    irq_level_out == (fifo_count_out >= fifo_thresh_in); endproperty
  property p_cap;      fifo_count_out <= 9'h100; endproperty
  property p_rd;       s_rd_ok |=> host_rvalid_out; endproperty
  property p_rd_empty; s_rd_empty |=> !host_rvalid_out; endproperty
  property p_mod;
    $past(arst_n_in) |-> tx_mod_out == $past(mod_scheme_select_in) && rx_mod_out == tx_mod_out;
  endproperty
  property p_decim;    filt_decim_out != 7'h00; endproperty

  a_empty:    assert property (p_empty) else $error("empty flag wrong");
  a_nempty:   assert property (p_nempty) else $error("not empty flag wrong");
  a_full:     assert property (p_full) else $error("full flag wrong");
  a_nfull:    assert property (p_nfull) else $error("not full flag wrong");
  a_level:    assert property (p_level) else $error("level flag wrong");
  a_cap:      assert property (p_cap) else $error("count above capacity");
  a_rd:       assert property (p_rd) else $error("read gave no data");
  a_rd_empty: assert property (p_rd_empty) else $error("empty read gave data");
  a_mod:      assert property (p_mod) else $error("modulation select wrong");
  a_decim:    assert property (p_decim) else $error("decimation zero");
endmodule

bind rff_framer rff_framer_chk u_chk (.mclk_in, .arst_n_in, .tx_mode_in, .fifo_thresh_in,
  .mod_scheme_select_in, .host_rd_in, .host_rvalid_out, .fifo_count_out, .irq_empty_out,
  .irq_not_empty_out, .irq_full_out, .irq_not_full_out, .irq_level_out, .filt_decim_out,
  .tx_mod_out, .rx_mod_out);

/* File: test/rff_host_model.sv */
/*
  Microcontroller model servicing the FIFO by polling its count.
  Assumes the bench raises requests at falling edges.
*/
`timescale 1ns/1ps

module rff_host_model (
  // Clock
  input  wire       mclk_in,
  // Bench requests
  input  wire       wr_req_in,
  input  wire [7:0] data_in,
  input  wire       rd_req_in,
  input  wire       force_in,
  // FIFO status
  input  wire [8:0] fifo_count_in,
  // FIFO port
  output reg        host_wr_out,
  output reg  [7:0] host_wdata_out,
  output reg        host_rd_out
);
  reg       wr_q;
  reg       rd_q;
  reg       frc_q;
  reg [7:0] data_q;

  // Requests caught on the rising edge, driven on the falling edge
  always @(posedge mclk_in) begin
    wr_q   <= wr_req_in;
    rd_q   <= rd_req_in;
    frc_q  <= force_in;
    data_q <= data_in;
  end
  // Force bypasses polling to provoke refusals
  always @(negedge mclk_in) begin
    host_wr_out    <= wr_q && (frc_q || fifo_count_in != 9'h100);
    host_wdata_out <= wr_q ? data_q : ~host_wdata_out;
    host_rd_out    <= rd_q && (frc_q || fifo_count_in != 9'h000);
  end
endmodule

/* File: test/rff_framer_bench.sv */
/*
  Self-checking bench for rff_framer: config, FIFO fill, coding, receive.
  Assumes rff_host_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps

module rff_framer_bench;
  reg        mclk_in, arst_n_in, tx_mode_in, frame_mode_in, mod_sym_strobe_in;
  reg        demod_sym_strobe_in, demod_bit_in, wr_req, rd_req, frc, w, lv;
  reg  [3:0] line_coding_config_in, mod_scheme_select_in;
  reg  [8:0] fifo_thresh_in, wh;
  reg  [6:0] channel_filter_decim_in;
  reg  [7:0] tx_freq_deviation_in, timing_loop_gain_in, rate_loop_gain_in, wdata, d0, b;
  wire       host_wr_in, host_rd_in, host_rvalid_out, irq_empty_out, irq_not_empty_out;
  wire       irq_full_out, irq_not_full_out, irq_level_out, chunk_start_out;
  wire       mod_bit_out, mod_active_out;
  wire [7:0] host_wdata_in, host_rdata_out, tx_dev_out, rx_tgain_out, rx_rgain_out;
  wire [8:0] fifo_count_out;
  wire [6:0] filt_decim_out;
  wire [3:0] tx_mod_out, rx_mod_out;
  integer    miscompares, n_checks, i, k, j;

  rff_framer u_dut (.*);
  rff_host_model u_host (.mclk_in, .wr_req_in(wr_req), .data_in(wdata), .rd_req_in(rd_req),
    .force_in(frc), .fifo_count_in(fifo_count_out), .host_wr_out(host_wr_in),
    .host_wdata_out(host_wdata_in), .host_rd_out(host_rd_in));

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  // ==========================================================
  // Helpers
  task end_of_test;
    begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk_val(input string nm, input [8:0] e, input [8:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_bit(input string nm, input e, input g);
    chk_val(nm, {8'h00, e}, {8'h00, g});
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk_in);
  endtask
  task timeout;
    miscompares++;
    $display("Error wait expected done seen timeout");
    end_of_test;
  endtask
  task do_reset;
    arst_n_in = 1'b0;
    wh = 9'h000;
    lv = 1'b0;
    cyc(4);
    arst_n_in = 1'b1;
    cyc(1);
  endtask
  task send_sym(input v);
    demod_bit_in = v;
    demod_sym_strobe_in = 1'b1;
    cyc(1);
    demod_sym_strobe_in = 1'b0;
    cyc(1);
  endtask
  // Line coding of a byte: whiten x^9+x^5+1, differential, invert, Manchester
  task send_byte(input [7:0] v, input [3:0] cfg);
    for (k = 0; k < 8; k++) begin
      w = v[k] ^ (cfg[3] & (wh[8] ^ wh[4]));
      wh = {wh[7:0], w};
      lv = cfg[1] ? (lv ^ w) : w;
      send_sym(lv ^ cfg[0]);
      if (cfg[2])
        send_sym(~(lv ^ cfg[0]));
    end
    demod_bit_in = ~demod_bit_in;
  endtask
  // Symbol k of a byte under invert and Manchester options
  function sym(input [7:0] d, input [3:0] cfg, input integer n);
    sym = d[cfg[2] ? n / 2 : n] ^ cfg[0] ^ (cfg[2] & n[0]);
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    {arst_n_in, tx_mode_in, frame_mode_in, mod_sym_strobe_in, demod_sym_strobe_in} = 5'h00;
    {demod_bit_in, wr_req, rd_req, frc} = 4'h0;
    {line_coding_config_in, mod_scheme_select_in, tx_freq_deviation_in} = 16'h0000;
    {timing_loop_gain_in, rate_loop_gain_in, wdata, d0, b} = 40'h00;
    fifo_thresh_in = 9'h080;
    channel_filter_decim_in = 7'h10;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(17912));
    do_reset;
    chk_val("count", 9'h000, fifo_count_out);
    chk_bit("empty", 1'b1, irq_empty_out);
    chk_bit("not_full", 1'b1, irq_not_full_out);
    chk_bit("chunk", 1'b1, chunk_start_out);
    for (i = 0; i < 4; i++) begin
      channel_filter_decim_in = (i == 0) ? 7'h00 : $urandom;
      {mod_scheme_select_in, tx_freq_deviation_in} = $urandom;
      {timing_loop_gain_in, rate_loop_gain_in} = $urandom;
      cyc(2);
      chk_val("decim", (i == 0) ? 9'h001 : {2'h0, channel_filter_decim_in},
              {2'h0, filt_decim_out});
      chk_val("tx_mod", {5'h00, mod_scheme_select_in}, {5'h00, tx_mod_out});
      chk_val("rx_mod", {5'h00, mod_scheme_select_in}, {5'h00, rx_mod_out});
      chk_val("tx_dev", {1'b0, tx_freq_deviation_in}, {1'b0, tx_dev_out});
      chk_val("tgain", {1'b0, timing_loop_gain_in}, {1'b0, rx_tgain_out});
      chk_val("rgain", {1'b0, rate_loop_gain_in}, {1'b0, rx_rgain_out});
    end
    // Transmit: fill to full, then clock out the first byte
    tx_mode_in = 1'b1;
    line_coding_config_in = 4'h5;
    cyc(1);
    wr_req = 1'b1;
    for (i = 0; i < 300 && fifo_count_out !== 9'h100; i++) begin
      wdata = $urandom;
      if (i == 0)
        d0 = wdata;
      cyc(1);
    end
    if (i == 300)
      timeout;
    frc = 1'b1;
    cyc(2);
    chk_val("count", 9'h100, fifo_count_out);
    chk_bit("full", 1'b1, irq_full_out);
    chk_bit("level", 1'b1, irq_level_out);
    frc = 1'b0;
    wr_req = 1'b0;
    cyc(2);
    chk_bit("active", 1'b1, mod_active_out);
    for (i = 0; i < 16; i++) begin
      mod_sym_strobe_in = 1'b1;
      cyc(1);
      mod_sym_strobe_in = 1'b0;
      cyc(1);
      chk_bit("mod_bit", sym(d0, 4'h5, i), mod_bit_out);
    end
    // Receive: raw mode plain, then packet mode with every coding option
    for (j = 0; j < 2; j++) begin
      do_reset;
      tx_mode_in = 1'b0;
      frame_mode_in = (j == 0);
      line_coding_config_in = (j == 0) ? 4'h0 : 4'hf;
      b = ($urandom % 255) + 1;
      send_byte(b, line_coding_config_in);
      for (i = 0; i < 20 && fifo_count_out !== 9'h001; i++)
        cyc(1);
      if (i == 20)
        timeout;
      chk_bit("empty", 1'b0, irq_empty_out);
      chk_bit("not_empty", 1'b1, irq_not_empty_out);
      rd_req = 1'b1;
      cyc(1);
      rd_req = 1'b0;
      for (i = 0; i < 6 && host_rvalid_out !== 1'b1; i++)
        cyc(1);
      if (i == 6)
        timeout;
      chk_val("rdata", {1'b0, b}, {1'b0, host_rdata_out});
    end
    // Read while empty is refused
    rd_req = 1'b1;
    frc = 1'b1;
    cyc(3);
    chk_bit("rvalid", 1'b0, host_rvalid_out);
    chk_val("count", 9'h000, fifo_count_out);
    {rd_req, frc} = 2'h0;
    // Packet mode drops an all-zero byte
    frame_mode_in = 1'b0;
    send_byte(8'h00, line_coding_config_in);
    cyc(10);
    chk_val("count", 9'h000, fifo_count_out);
    end_of_test;
  end
endmodule
